// [common/cfg_defines.svh]
// Offsets, field positions and reset values of the loader
`ifndef CFG_DEFINES_SVH
`define CFG_DEFINES_SVH
// ==========================================
// APB byte offsets
`define CFG_OFS_CODE_PROTECT 8'h00
`define CFG_OFS_BOOT_LIMIT 8'h10
`define CFG_OFS_SIGNATURE 8'h14
`define CFG_OFS_OSC_SELECT 8'h18
`define CFG_OFS_OSC_OPTIONS 8'h1C
`define CFG_OFS_STATUS 8'h40
`define CFG_OFS_CONTROL 8'h44
`define CFG_OFS_UNLOCK 8'h48
// ==========================================
// Storage word indices
`define CFG_IDX_CODE_PROTECT 3'h0
`define CFG_IDX_BOOT_LIMIT 3'h1
`define CFG_IDX_SIGNATURE 3'h2
`define CFG_IDX_OSC_SELECT 3'h3
`define CFG_IDX_OSC_OPTIONS 3'h4
`define CFG_WORD_COUNT 3'h5
// ==========================================
// Unimplemented bits, read as one
`define CFG_UNIMPL_CODE_PROTECT 24'hFF7010
`define CFG_UNIMPL_BOOT_LIMIT 24'hFFE000
`define CFG_UNIMPL_SIGNATURE 24'hFF7FFF
`define CFG_UNIMPL_OSC_SELECT 24'hFFFC00
`define CFG_UNIMPL_OSC_OPTIONS 24'hFFFF00
// Erased word, held until loaded
`define CFG_ERASED_WORD 24'hFFFFFF
// ==========================================
// Field positions, code protect word
`define CFG_POS_AVT_DISABLE 15
`define CFG_POS_CS_LEVEL 9
`define CFG_POS_CS_WP_N 8
`define CFG_POS_GS_LEVEL 6
`define CFG_POS_GS_WP_N 5
`define CFG_POS_BS_DISABLE 3
`define CFG_POS_BS_LEVEL 1
`define CFG_POS_BS_WP_N 0
// Field positions, oscillator words
`define CFG_POS_TWO_SPEED 7
`define CFG_POS_FREQ_MULT 3
`define CFG_POS_INIT_OSC 0
`define CFG_POS_CLK_SW_MON 6
`define CFG_POS_PIN_ONE_WAY 5
`define CFG_POS_MULT_SRC 4
`define CFG_POS_SEC_OSC_MODE 3
`define CFG_POS_CLK_OUT_EN 2
`define CFG_POS_PRI_OSC_MODE 0
// ==========================================
// Control bits and unlock keys
`define CFG_CTRL_PIN_LOCK 0
`define CFG_CTRL_AVT_ENABLE 1
`define CFG_CTRL_MULT_ENABLE 2
`define CFG_UNLOCK_KEY1 32'h0000_0046
`define CFG_UNLOCK_KEY2 32'h0000_0057
`endif

// [common/cfg_pkg.sv]
// Types shared by the configuration loader and its users
package cfg_pkg;
  // ==========================================
  // Protection level of a code segment
  typedef enum logic [1:0] {
    PROT_NONE, PROT_STANDARD, PROT_ENHANCED, PROT_HIGH
  } prot_level_t;
  // Oscillator sources of the initial selection
  typedef enum logic [2:0] {
    OSC_FAST_RC, OSC_FAST_RC_PLL, OSC_PRIMARY, OSC_PRIMARY_PLL,
    OSC_SECONDARY, OSC_LOW_POWER_RC, OSC_RESERVED, OSC_DIVIDED
  } osc_src_t;
  // Multiplier mode
  typedef enum logic [2:0] {
    MULT_NONE, MULT_X4, MULT_X6, MULT_X8, MULT_96MHZ, MULT_UNDEFINED
  } mult_mode_t;
  // Primary oscillator mode
  typedef enum logic [1:0] {
    PRI_EXT_CLOCK, PRI_XT_CRYSTAL, PRI_HS_CRYSTAL, PRI_DISABLED
  } pri_osc_t;
  // ==========================================
  // Decoded security settings
  typedef struct packed {
    logic alt_vector_table_disable;
    prot_level_t config_segment_protect_level;
    logic config_segment_write_blocked;
    prot_level_t general_segment_protect_level;
    logic general_segment_write_blocked;
    logic boot_segment_active;
    prot_level_t boot_segment_protect_level;
    logic boot_segment_write_blocked;
    logic [12:0] boot_first_general_page;
    logic [12:0] boot_segment_pages;
  } security_t;
  // Decoded clock settings
  typedef struct packed {
    logic two_speed_startup_enable;
    osc_src_t initial_osc_select;
    osc_src_t startup_osc;
    mult_mode_t mult_mode;
    logic [5:0] mult_input_mhz;
    logic clock_switch_enable;
    logic fail_safe_monitor_enable;
    logic pin_lock_one_way;
    logic mult_source_primary;
    logic mult_source_in_effect;
    logic secondary_osc_crystal;
    logic clock_output_active;
    pri_osc_t primary_osc_mode;
  } clocking_t;
endpackage

// [dv/cfg_decode_monitor.sv]
// Port checker for the configuration loader, bound to its top module
`timescale 1ns/100ps
module cfg_decode_monitor (
  input logic clk_in,
  input logic nrst_in,
  input logic dev_reset_in,
  input logic cfg_req_out,
  input logic [2:0] cfg_index_out,
  input logic cfg_valid_in,
  input logic cfg_loaded_out,
  input cfg_pkg::security_t security_out,
  input cfg_pkg::clocking_t clocking_out,
  input logic pin_select_lock_out,
  input logic alt_vector_table_enable_out,
  input logic multiplier_enable_out
);
  import cfg_pkg::*;
  // ==========================================
  // One clock domain; reset voids every check
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  // Gated enables
  avt_gate_a: assert property (alt_vector_table_enable_out |->
    !security_out.alt_vector_table_disable) else $error("avt gate");
  mult_gate_a: assert property (multiplier_enable_out |->
    clocking_out.mult_mode != MULT_NONE) else $error("mult gate");
  // Boot size versus active
  boot_empty_a: assert property (!security_out.boot_segment_active |->
    security_out.boot_segment_pages == 13'h0000) else $error("boot empty");
  boot_size_a: assert property (security_out.boot_segment_active |->
    security_out.boot_segment_pages != 13'h0000) else $error("boot size");
  // Clock fields
  monitor_pair_a: assert property (clocking_out.fail_safe_monitor_enable |->
    clocking_out.clock_switch_enable) else $error("monitor pair");
  clk_out_gate_a: assert property (clocking_out.clock_output_active |->
    clocking_out.primary_osc_mode inside {PRI_DISABLED, PRI_EXT_CLOCK})
    else $error("clk out gate");
  startup_src_a: assert property (clocking_out.startup_osc ==
    (clocking_out.two_speed_startup_enable ? OSC_FAST_RC : clocking_out.initial_osc_select))
    else $error("startup src");
  mult_src_a: assert property (clocking_out.mult_source_in_effect ==
    !(clocking_out.initial_osc_select inside {OSC_FAST_RC_PLL, OSC_PRIMARY_PLL}))
    else $error("mult src");
  // Load ends after word 4; reset restarts it
  load_end_a: assert property (cfg_req_out && cfg_valid_in && cfg_index_out == 3'h4
    && !dev_reset_in |=> cfg_loaded_out && !cfg_req_out) else $error("load end");
  reload_a: assert property (dev_reset_in |=> !cfg_loaded_out && cfg_req_out
    && cfg_index_out == 3'h0) else $error("reload");
  // One-way lock holds
  lock_hold_a: assert property (clocking_out.pin_lock_one_way && pin_select_lock_out
    && !dev_reset_in |=> pin_select_lock_out) else $error("lock hold");
endmodule // cfg_decode_monitor

bind config_word_security_osc_decode cfg_decode_monitor mon (
  .clk_in(clk_in), .nrst_in(nrst_in), .dev_reset_in(dev_reset_in),
  .cfg_req_out(cfg_req_out), .cfg_index_out(cfg_index_out), .cfg_valid_in(cfg_valid_in),
  .cfg_loaded_out(cfg_loaded_out), .security_out(security_out), .clocking_out(clocking_out),
  .pin_select_lock_out(pin_select_lock_out),
  .alt_vector_table_enable_out(alt_vector_table_enable_out),
  .multiplier_enable_out(multiplier_enable_out)
);

// [dv/config_word_security_osc_decode_tb_top.sv]
// Self-checking testbench for the configuration loader
`timescale 1ns/100ps
`include "cfg_defines.svh"
module config_word_security_osc_decode_tb_top;
  import cfg_pkg::*;
  // ==========================================
  // Stimulus, observed outputs and tables
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic dev_reset_in = 1'b0;
  logic [23:0] cfg_data_in = 24'h000000;
  logic cfg_valid_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h00000000;
  logic [31:0] prdata_out, wrd;
  logic pready_out, pslverr_out, cfg_req_out, cfg_loaded_out, werr;
  logic [2:0] cfg_index_out;
  logic pin_select_lock_out, alt_vector_table_enable_out, multiplier_enable_out;
  security_t security_out;
  clocking_t clocking_out;
  int fail_count = 0;
  int checks = 0;
  logic [23:0] words [0:4];
  logic [7:0] ofs [0:4] = '{`CFG_OFS_CODE_PROTECT, `CFG_OFS_BOOT_LIMIT, `CFG_OFS_SIGNATURE,
    `CFG_OFS_OSC_SELECT, `CFG_OFS_OSC_OPTIONS};
  logic [23:0] unimpl [0:4] = '{`CFG_UNIMPL_CODE_PROTECT, `CFG_UNIMPL_BOOT_LIMIT,
    `CFG_UNIMPL_SIGNATURE, `CFG_UNIMPL_OSC_SELECT, `CFG_UNIMPL_OSC_OPTIONS};
  int mhz_tab [0:7] = '{4, 8, 12, 16, 20, 24, 32, 48};

  always #4 clk_in = ~clk_in;

  config_word_security_osc_decode #(.ADDR_W(8)) uut (
    .clk_in(clk_in), .nrst_in(nrst_in), .dev_reset_in(dev_reset_in),
    .cfg_req_out(cfg_req_out), .cfg_index_out(cfg_index_out), .cfg_data_in(cfg_data_in),
    .cfg_valid_in(cfg_valid_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .cfg_loaded_out(cfg_loaded_out), .security_out(security_out),
    .clocking_out(clocking_out), .pin_select_lock_out(pin_select_lock_out),
    .alt_vector_table_enable_out(alt_vector_table_enable_out),
    .multiplier_enable_out(multiplier_enable_out)
  );

  // Storage answers every other cycle
  always @(posedge clk_in) begin
    if (nrst_in && cfg_req_out === 1'b1 && !cfg_valid_in && !dev_reset_in) begin
      cfg_valid_in <= 1'b1;
      cfg_data_in <= words[cfg_index_out];
    end else begin
      cfg_valid_in <= 1'b0;
      cfg_data_in <= ~cfg_data_in; // Stale data keeps moving
    end
  end

  // ==========================================
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  // One APB transfer, held until pready at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge clk_in);
    penable_in <= 1'b1;
    @(posedge clk_in);
    while (pready_out !== 1'b1) @(posedge clk_in);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask

  // Write, then one edge for it to land
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, wrd, werr);
    @(posedge clk_in);
  endtask

  task automatic unlock(input logic [31:0] v);
    wr(`CFG_OFS_UNLOCK, `CFG_UNLOCK_KEY1);
    wr(`CFG_OFS_UNLOCK, `CFG_UNLOCK_KEY2);
    wr(`CFG_OFS_CONTROL, v);
  endtask

  // New words, device reset, load wait, readback
  task automatic reload(input logic [23:0] cp, input logic [23:0] bl,
                        input logic [23:0] os, input logic [23:0] oo);
    logic [31:0] rd;
    logic err;
    words = '{cp, bl, 24'hFF7FFF, os, oo};
    @(posedge clk_in);
    dev_reset_in <= 1'b1;
    @(posedge clk_in);
    dev_reset_in <= 1'b0;
    @(posedge clk_in);
    for (int n = 0; n < 40 && cfg_loaded_out !== 1'b1; n++) @(posedge clk_in);
    chk(32'(cfg_loaded_out), 32'h1, "loaded");
    chk(32'(pin_select_lock_out), 32'h0, "lock cleared");
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ofs[i], 32'h0, rd, err);
      chk(rd, {8'h00, words[i] | unimpl[i]}, "readback");
    end
  endtask

  function automatic prot_level_t lvl(input logic [1:0] v);
    return (v == 2'h3) ? PROT_NONE : (v == 2'h2) ? PROT_STANDARD : PROT_HIGH;
  endfunction

  // ==========================================
  // Scenarios
  task automatic t_security();
    logic [2:0] k;
    prot_level_t cs_e;
    security_t s;
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      cs_e = (k == 3'h7) ? PROT_NONE : (k == 3'h6) ? PROT_STANDARD :
             k[2] ? PROT_ENHANCED : PROT_HIGH;
      reload({8'hFF, k[0], 3'h7, k, ~k[0], k[1:0], k[0], 1'b1, k[1], k[1:0], ~k[1]},
             24'hFFFFFF, 24'hFFFCFF, 24'hFFFFFF);
      s = security_out;
      chk(32'(s.config_segment_protect_level), 32'(cs_e), "cs level");
      chk(32'(s.general_segment_protect_level), 32'(lvl(k[1:0])), "gs level");
      chk(32'(s.boot_segment_protect_level), 32'(lvl(k[1:0])), "bs level");
      chk(32'(s.config_segment_write_blocked), 32'(k[0]), "cs wp");
      chk(32'(s.general_segment_write_blocked), 32'(!k[0]), "gs wp");
      chk(32'(s.boot_segment_write_blocked), 32'(k[1]), "bs wp");
      wr(`CFG_OFS_CONTROL, 32'h2);
      chk(32'(alt_vector_table_enable_out), 32'(!k[0]), "avt");
    end
  endtask

  task automatic boot_case(input logic dis, input logic [12:0] lim, input logic act,
                           input logic [12:0] pg);
    reload({20'hFFFFF, dis, 3'h7}, {11'h7FF, lim}, 24'hFFFCFF, 24'hFFFFFF);
    chk(32'(security_out.boot_segment_active), 32'(act), "bs active");
    chk(32'(security_out.boot_segment_pages), 32'(pg), "bs pages");
    chk(32'(security_out.boot_first_general_page), {19'h0, ~lim}, "first page");
  endtask

  task automatic t_osc();
    logic [3:0] m;
    mult_mode_t me;
    clocking_t c;
    for (int i = 0; i < 16; i++) begin
      m = i[3:0];
      me = (m == 4'hF) ? MULT_NONE : (m == 4'hE) ? MULT_X8 : (m == 4'hD) ? MULT_X6 :
           (m == 4'hC) ? MULT_X4 : m[3] ? MULT_UNDEFINED : MULT_96MHZ;
      reload(24'hFFFFFF, 24'hFFFFFF, {14'h3FFF, 2'b00, m[0], m, m[2:0]}, {16'hFFFF, m, m});
      wr(`CFG_OFS_CONTROL, 32'h4);
      c = clocking_out;
      chk(32'(c.mult_mode), 32'(me), "mult mode");
      if (!m[3]) chk(32'(c.mult_input_mhz), mhz_tab[m[2:0]], "mhz");
      chk(32'(multiplier_enable_out), 32'(m != 4'hF), "mult en");
      chk(32'(c.initial_osc_select), 32'(osc_src_t'(m[2:0])), "init osc");
      chk(32'(c.two_speed_startup_enable), 32'(m[0]), "two speed");
      chk(32'(c.startup_osc), 32'(m[0] ? OSC_FAST_RC : osc_src_t'(m[2:0])), "start osc");
      chk(32'({c.mult_source_in_effect, c.mult_source_primary}),
          32'({m[2] | ~m[0], m[0]}), "mult src");
      chk(32'(c.clock_switch_enable), 32'(!m[3]), "sw");
      chk(32'(c.fail_safe_monitor_enable), 32'(m[3:2] == 2'h0), "monitor");
      chk(32'(c.pin_lock_one_way), 32'(m[1]), "one way");
      chk(32'(c.secondary_osc_crystal), 32'(m[3]), "sec osc");
      chk(32'(c.clock_output_active), 32'(m[2] && (m[1:0] == 2'h3 || m[1:0] == 2'h0)),
          "clk out");
      chk(32'(c.primary_osc_mode), 32'(pri_osc_t'(m[1:0])), "pri osc");
    end
  endtask

  // Lock needs the key; one-way keeps it set
  task automatic t_lock();
    for (int ow = 0; ow < 2; ow++) begin
      reload(24'hFFFFFF, 24'hFFFFFF, 24'hFFFCFF, {18'h3FFFF, ow[0], 5'h1F});
      wr(`CFG_OFS_CONTROL, 32'h1);
      chk(32'(pin_select_lock_out), 32'h0, "no key");
      unlock(32'h1);
      chk(32'(pin_select_lock_out), 32'h1, "lock set");
      unlock(32'h0);
      chk(32'(pin_select_lock_out), 32'(ow[0]), "lock clear");
      unlock(32'h1);
      chk(32'(pin_select_lock_out), 32'h1, "relock");
    end
  endtask

  // Refused writes change nothing
  task automatic t_refuse();
    logic [31:0] rd;
    logic err;
    apb(1'b1, `CFG_OFS_CODE_PROTECT, 32'h0, rd, err);
    chk(32'(err), 32'h1, "wr word");
    apb(1'b0, `CFG_OFS_CODE_PROTECT, 32'h0, rd, err);
    chk(rd, {8'h00, words[0] | unimpl[0]}, "word kept");
    apb(1'b0, 8'h04, 32'h0, rd, err);
    chk(32'(err), 32'h1, "unmapped");
    apb(1'b0, `CFG_OFS_STATUS, 32'h0, rd, err);
    chk(32'(rd[0]), 32'h1, "status");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial begin
    words = '{default: 24'hFFFFFF};
    repeat (6) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_security();
    boot_case(1'b0, 13'h1FFF, 1'b0, 13'h0000);
    boot_case(1'b0, 13'h1FF0, 1'b1, 13'h000F);
    boot_case(1'b0, 13'h1F00, 1'b1, 13'h00FF);
    boot_case(1'b1, 13'h1000, 1'b0, 13'h0000);
    t_osc();
    t_lock();
    t_refuse();
    tally_and_finish();
  end

  // Twenty times the expected 1000 cycles means a hang
  initial begin
    #(8 * 20000);
    fail_count++;
    $display("[ERR] t=%0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule // config_word_security_osc_decode_tb_top

// [rtl/config_word_security_osc_decode.sv]
// Configuration word loader with security and oscillator decode and APB view
//
// Overview of operation
// - Unimplemented bits of every configuration word read back as one.
// - Disable bit set kills alternate vector table and its enable bit.
// - Config segment level: 111 none, 110 standard, 10x enhanced, 0xx high.
// - General segment level: 11 none, 10 standard, 0x high.
// - Boot segment level: 11 none, 10 standard, 0x high.
// - Segment write-protect bits are active low; zero blocks writes.
// - Boot control bit one means no boot segment; zero uses limit.
// - Boot limit holds first general page after last boot page.
// - Boot limit is stored inverted; more zeros only grow boot segment.
// - Boot limit of all ones gives a zero-size boot segment.
// - Two-speed bit starts on fast RC, then switches to selected source.
// - Multiplier 1111 none and enable unusable; 1110 8x, 1101 6x, 1100 4x.
// - Codes 0000-0111 select 96 MHz PLL with inputs 4 to 48 MHz.
// - Initial oscillator select decodes eight sources, 110 reserved.
// - Switch field: 1x both off, 01 switching only, 00 both on.
// - One-way bit lets pin lock be set once; else set and clear.
// - Multiplier source bit acts only while PLL not in system clock.
// - Secondary oscillator bit: one crystal mode, zero external clock.
// - Clock out only when enabled and primary disabled or external.
// - Primary mode: 11 off, 10 HS crystal, 01 XT crystal, 00 external.
// - Every reset reloads all configuration words from storage.
`timescale 1ns/100ps
`include "cfg_defines.svh"

module config_word_security_osc_decode #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  // Other reset sources of the device, one-cycle pulse
  input wire logic dev_reset_in,
  // Storage read port
  output logic cfg_req_out,
  output logic [2:0] cfg_index_out,
  input wire logic [23:0] cfg_data_in,
  input wire logic cfg_valid_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Decoded settings
  output logic cfg_loaded_out,
  output cfg_pkg::security_t security_out,
  output cfg_pkg::clocking_t clocking_out,
  output logic pin_select_lock_out,
  output logic alt_vector_table_enable_out,
  output logic multiplier_enable_out
);
  import cfg_pkg::*;

  // ==========================================
  // Load sequencer

  typedef enum logic {
    ST_LOAD,
    ST_READY
  } load_state_t;

  load_state_t state_q;
  load_state_t state_d;
  logic [2:0] index_q;
  logic [2:0] index_d;
  logic [23:0] word_q [5];
  logic [23:0] unimpl_mask [5];
  logic take_word;

  // Per-word unimplemented masks
  assign unimpl_mask[0] = `CFG_UNIMPL_CODE_PROTECT;
  assign unimpl_mask[1] = `CFG_UNIMPL_BOOT_LIMIT;
  assign unimpl_mask[2] = `CFG_UNIMPL_SIGNATURE;
  assign unimpl_mask[3] = `CFG_UNIMPL_OSC_SELECT;
  assign unimpl_mask[4] = `CFG_UNIMPL_OSC_OPTIONS;

  assign take_word = (state_q == ST_LOAD) && cfg_valid_in;
  assign cfg_req_out = (state_q == ST_LOAD);
  assign cfg_index_out = index_q;
  assign cfg_loaded_out = (state_q == ST_READY);

  // Next state; any reset restarts the load
  always_comb begin
    state_d = state_q;
    index_d = index_q;
    case (state_q)
      ST_LOAD: begin
        if (take_word) begin
          index_d = index_q + 3'h1;
          if (index_q == `CFG_WORD_COUNT - 3'h1) begin
            state_d = ST_READY;
          end
        end
      end
      ST_READY: begin
        index_d = 3'h0;
      end
      default: begin
        state_d = ST_LOAD;
        index_d = 3'h0;
      end
    endcase
    if (dev_reset_in) begin
      state_d = ST_LOAD;
      index_d = 3'h0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_LOAD;
      index_q <= 3'h0;
    end else begin
      state_q <= state_d;
      index_q <= index_d;
    end
  end

  // Erased until loaded; unimplemented bits forced high
  // so no stray zero leaks downstream
  for (genvar gi = 0; gi < 5; gi++) begin : g_word
    always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        word_q[gi] <= `CFG_ERASED_WORD;
      end else if (dev_reset_in) begin
        word_q[gi] <= `CFG_ERASED_WORD;
      end else if (take_word && index_q == 3'(gi)) begin
        word_q[gi] <= cfg_data_in | unimpl_mask[gi];
      end
    end
  end

  // ==========================================
  // Security decode

  logic [23:0] w_sec;
  logic [23:0] w_lim;
  logic [23:0] w_sel;
  logic [23:0] w_opt;
  logic [2:0] cs_field;
  logic [1:0] gs_field;
  logic [1:0] bs_field;
  logic bs_disable;
  logic [12:0] lim_field;

  assign w_sec = word_q[0];
  assign w_lim = word_q[1];
  assign w_sel = word_q[3];
  assign w_opt = word_q[4];
  assign cs_field = w_sec[`CFG_POS_CS_LEVEL +: 3];
  assign gs_field = w_sec[`CFG_POS_GS_LEVEL +: 2];
  assign bs_field = w_sec[`CFG_POS_BS_LEVEL +: 2];
  assign bs_disable = w_sec[`CFG_POS_BS_DISABLE];
  assign lim_field = w_lim[12:0];

  // Two-bit level shared by general and boot segments
  function automatic prot_level_t level2(input logic [1:0] f);
    prot_level_t l;
    l = PROT_HIGH;
    if (f == 2'h3) begin
      l = PROT_NONE;
    end else if (f == 2'h2) begin
      l = PROT_STANDARD;
    end
    return l;
  endfunction

  // Three-bit configuration segment level
  function automatic prot_level_t level3(input logic [2:0] f);
    prot_level_t l;
    l = PROT_HIGH;
    if (f == 3'h7) begin
      l = PROT_NONE;
    end else if (f == 3'h6) begin
      l = PROT_STANDARD;
    end else if (f[2]) begin
      l = PROT_ENHANCED;
    end
    return l;
  endfunction

  // Inverted limit is the first general page, so the boot
  // segment spans that many pages; erased gives zero
  always_comb begin
    security_out.alt_vector_table_disable = w_sec[`CFG_POS_AVT_DISABLE];
    security_out.config_segment_protect_level = level3(cs_field);
    security_out.general_segment_protect_level = level2(gs_field);
    security_out.boot_segment_protect_level = level2(bs_field);
    security_out.config_segment_write_blocked = !w_sec[`CFG_POS_CS_WP_N];
    security_out.general_segment_write_blocked = !w_sec[`CFG_POS_GS_WP_N];
    security_out.boot_segment_write_blocked = !w_sec[`CFG_POS_BS_WP_N];
    security_out.boot_first_general_page = ~lim_field;
    if (bs_disable) begin
      security_out.boot_segment_active = 1'b0;
      security_out.boot_segment_pages = 13'h0000;
    end else begin
      security_out.boot_segment_pages = ~lim_field;
      security_out.boot_segment_active = (lim_field != 13'h1FFF);
    end
  end

  // ==========================================
  // Clock decode

  logic [3:0] mult_field;
  logic [1:0] sw_field;
  logic [1:0] pri_field;
  logic pll_in_sys_clock;

  assign mult_field = w_sel[`CFG_POS_FREQ_MULT +: 4];
  assign sw_field = w_opt[`CFG_POS_CLK_SW_MON +: 2];
  assign pri_field = w_opt[`CFG_POS_PRI_OSC_MODE +: 2];
  assign pll_in_sys_clock = (w_sel[2:0] == 3'h1) || (w_sel[2:0] == 3'h3);

  // Input frequency for the 96 MHz mode, in MHz
  function automatic logic [5:0] mult_in_mhz(input logic [2:0] c);
    logic [5:0] m;
    case (c)
      3'h0: m = 6'd4;
      3'h1: m = 6'd8;
      3'h2: m = 6'd12;
      3'h3: m = 6'd16;
      3'h4: m = 6'd20;
      3'h5: m = 6'd24;
      3'h6: m = 6'd32;
      default: m = 6'd48;
    endcase
    return m;
  endfunction

  // Codes 1000..1011 are undocumented; flagged rather than guessed
  always_comb begin
    clocking_out.mult_input_mhz = 6'd0;
    case (mult_field)
      4'hF: clocking_out.mult_mode = MULT_NONE;
      4'hE: clocking_out.mult_mode = MULT_X8;
      4'hD: clocking_out.mult_mode = MULT_X6;
      4'hC: clocking_out.mult_mode = MULT_X4;
      default: begin
        clocking_out.mult_mode = MULT_UNDEFINED;
        if (!mult_field[3]) begin
          clocking_out.mult_mode = MULT_96MHZ;
          clocking_out.mult_input_mhz = mult_in_mhz(mult_field[2:0]);
        end
      end
    endcase
  end

  // Remaining clock fields
  always_comb begin
    clocking_out.two_speed_startup_enable = w_sel[`CFG_POS_TWO_SPEED];
    clocking_out.initial_osc_select = osc_src_t'(w_sel[2:0]);
    clocking_out.startup_osc = w_sel[`CFG_POS_TWO_SPEED] ?
        OSC_FAST_RC : osc_src_t'(w_sel[2:0]);
    clocking_out.clock_switch_enable = !sw_field[1];
    clocking_out.fail_safe_monitor_enable = (sw_field == 2'h0);
    clocking_out.pin_lock_one_way = w_opt[`CFG_POS_PIN_ONE_WAY];
    clocking_out.mult_source_primary = w_opt[`CFG_POS_MULT_SRC];
    clocking_out.mult_source_in_effect = !pll_in_sys_clock;
    clocking_out.secondary_osc_crystal = w_opt[`CFG_POS_SEC_OSC_MODE];
    clocking_out.primary_osc_mode = pri_osc_t'(pri_field);
    clocking_out.clock_output_active = w_opt[`CFG_POS_CLK_OUT_EN] &&
        (pri_field == 2'h3 || pri_field == 2'h0);
  end

  // ==========================================
  // APB decode

  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic hit_word;
  logic hit_status;
  logic hit_ctrl;
  logic hit_unlock;
  logic mapped;
  logic [2:0] word_sel;
  logic [31:0] rd_value;

  assign setup_ph = psel_in && !penable_in;
  assign access_ph = psel_in && penable_in;
  assign hit_status = (paddr_in == `CFG_OFS_STATUS);
  assign hit_ctrl = (paddr_in == `CFG_OFS_CONTROL);
  assign hit_unlock = (paddr_in == `CFG_OFS_UNLOCK);
  assign word_sel = (paddr_in == `CFG_OFS_BOOT_LIMIT) ? `CFG_IDX_BOOT_LIMIT :
      (paddr_in == `CFG_OFS_SIGNATURE) ? `CFG_IDX_SIGNATURE :
      (paddr_in == `CFG_OFS_OSC_SELECT) ? `CFG_IDX_OSC_SELECT :
      (paddr_in == `CFG_OFS_OSC_OPTIONS) ? `CFG_IDX_OSC_OPTIONS :
      `CFG_IDX_CODE_PROTECT;
  assign hit_word = (paddr_in == `CFG_OFS_CODE_PROTECT) ||
      (word_sel != `CFG_IDX_CODE_PROTECT);
  assign mapped = hit_word || hit_status || hit_ctrl || hit_unlock;
  // Words are read only, so a write to them is an error too
  assign pslverr_out = access_ph && (!mapped || (pwrite_in && hit_word));
  assign pready_out = 1'b1;
  assign wr_en = access_ph && pwrite_in && !pslverr_out;

  // Read mux; upper byte of each word reads zero on the 32-bit bus
  assign rd_value = hit_word ? {8'h00, word_q[word_sel]} :
      hit_status ? {31'h0, cfg_loaded_out} :
      hit_ctrl ? {29'h0, multiplier_enable_out,
                  alt_vector_table_enable_out, pin_select_lock_out} :
      32'h0000_0000;

  // Read data captured at setup, from a flop
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (setup_ph && !pwrite_in) begin
      prdata_out <= rd_value;
    end
  end

  // ==========================================
  // Unlock sequence and run-time control bits

  logic key1_seen_q;
  logic unlocked_q;
  logic lock_q;
  logic lock_d;
  logic avt_en_q;
  logic mult_en_q;

  // Two key writes in a row open the pin lock bit to one control write
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      key1_seen_q <= 1'b0;
      unlocked_q <= 1'b0;
    end else if (wr_en && hit_unlock) begin
      key1_seen_q <= (pwdata_in == `CFG_UNLOCK_KEY1);
      unlocked_q <= key1_seen_q && (pwdata_in == `CFG_UNLOCK_KEY2);
    end else if (wr_en) begin
      key1_seen_q <= 1'b0;
      unlocked_q <= 1'b0;
    end
  end

  // One-way policy keeps a set lock until reset
  always_comb begin
    lock_d = lock_q;
    if (wr_en && hit_ctrl && unlocked_q) begin
      if (w_opt[`CFG_POS_PIN_ONE_WAY]) begin
        lock_d = lock_q | pwdata_in[`CFG_CTRL_PIN_LOCK];
      end else begin
        lock_d = pwdata_in[`CFG_CTRL_PIN_LOCK];
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lock_q <= 1'b0;
      avt_en_q <= 1'b0;
      mult_en_q <= 1'b0;
    end else if (dev_reset_in) begin
      lock_q <= 1'b0;
      avt_en_q <= 1'b0;
      mult_en_q <= 1'b0;
    end else begin
      lock_q <= lock_d;
      if (wr_en && hit_ctrl) begin
        avt_en_q <= pwdata_in[`CFG_CTRL_AVT_ENABLE];
        mult_en_q <= pwdata_in[`CFG_CTRL_MULT_ENABLE];
      end
    end
  end

  // Enables unavailable when the stored word forbids them
  assign alt_vector_table_enable_out = avt_en_q &&
      !w_sec[`CFG_POS_AVT_DISABLE];
  assign multiplier_enable_out = mult_en_q && (mult_field != 4'hF);
  assign pin_select_lock_out = lock_q;

endmodule // config_word_security_osc_decode
